// File: ct3_timer.sv
// Third countdown timer with AXI4-Lite register access
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module ct3_timer
#(
   parameter int CNT_W = 16
)
(
   input  wire logic                       mclk,
   input  wire logic                       rst_b,
   input  wire logic [ct3_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [ct3_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [ct3_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [ct3_pkg::DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       sys_tick,
   input  wire logic                       carrier_tick,
   input  wire logic                       timer_zero_underflow,
   input  wire logic                       timer_one_underflow,
   input  wire logic                       tx_end,
   input  wire logic                       rx_first_nibble,
   input  wire logic                       lpcd_start,
   input  wire logic                       low_frequency_oscillator,
   output logic                            underflow_pulse,
   output logic                            timer_running,
   output logic                            lpcd_field_on,
   output logic                            irq
);

   logic [7:0]              ctrl_reg;
   logic [CNT_W-1:0]        reload_reg;
   logic [CNT_W-1:0]        count_reg;
   logic [ct3_pkg::ST_W-1:0] status_reg;
   logic [ct3_pkg::ST_W-1:0] mask_reg;
   ct3_pkg::ct3_state_e     state_reg;
   logic                    field_reg;
   logic                    uf_reg;

   // Bus holding registers
   logic                       aw_full_reg;
   logic                       w_full_reg;
   logic [ct3_pkg::ADDR_W-1:0] aw_addr_reg;
   logic [ct3_pkg::DATA_W-1:0] w_data_reg;
   logic [3:0]                 w_strb_reg;
   logic                       bvalid_reg;
   logic [1:0]                 bresp_reg;
   logic                       rvalid_reg;
   logic [1:0]                 rresp_reg;
   logic [ct3_pkg::DATA_W-1:0] rdata_reg;

   // Oscillator pin synchroniser; second and third stage must agree
   logic lfo_s1_reg;
   logic lfo_s2_reg;
   logic lfo_s3_reg;
   logic lfo_lvl_reg;
   logic lfo_edge;

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lfo_s1_reg  <= 1'b0;
         lfo_s2_reg  <= 1'b0;
         lfo_s3_reg  <= 1'b0;
         lfo_lvl_reg <= 1'b0;
      end
      else
      begin
         lfo_s1_reg <= low_frequency_oscillator;
         lfo_s2_reg <= lfo_s1_reg;
         lfo_s3_reg <= lfo_s2_reg;
         if (lfo_s2_reg == lfo_s3_reg)
            lfo_lvl_reg <= lfo_s3_reg;
      end
   end

   assign lfo_edge = (lfo_s2_reg == lfo_s3_reg) && lfo_s3_reg && !lfo_lvl_reg;

   // Control field decode
   logic [1:0] src;
   logic [1:0] clk_sel;
   logic       trim_mode;
   logic       running;
   assign src       = ctrl_reg[ct3_pkg::CTRL_SRC_HI:ct3_pkg::CTRL_SRC_LO];
   assign clk_sel   = ctrl_reg[ct3_pkg::CTRL_CLK_HI:ct3_pkg::CTRL_CLK_LO];
   assign trim_mode = src[1];
   assign running   = (state_reg == ct3_pkg::CT3_RUN);

   // Count tick selection
   logic tick;
   always_comb
   begin
      case (clk_sel)
         ct3_pkg::CLK_SYS:     tick = sys_tick;             // see [RULE10]
         ct3_pkg::CLK_CARRIER: tick = carrier_tick;         // see [RULE10]
         ct3_pkg::CLK_T0_UF:   tick = timer_zero_underflow; // see [RULE11]
         ct3_pkg::CLK_T1_UF:   tick = timer_one_underflow;  // see [RULE11]
         default:              tick = 1'b0;
      endcase
   end

   // Register write decode
   logic                       wr_fire;
   logic [7:0]                 wr_idx;
   logic                       wr_lane;
   logic                       wr_map;
   logic                       sw_start;
   logic                       sw_stop;
   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_idx  = 8'(aw_addr_reg[ct3_pkg::ADDR_W-1:2]);
   assign wr_lane = w_strb_reg[0];
   // Two contiguous index runs: timer bytes, then status/mask/command
   assign wr_map  = (aw_addr_reg[1:0] == 2'h0) &&
                    ((wr_idx >= ct3_pkg::IDX_CTRL &&
                      wr_idx <= ct3_pkg::IDX_CNT_LO) ||
                     (wr_idx >= ct3_pkg::IDX_STATUS &&
                      wr_idx <= ct3_pkg::IDX_COMMAND));
   assign sw_start = wr_fire && wr_lane && wr_idx == ct3_pkg::IDX_COMMAND &&
                     w_data_reg[ct3_pkg::CMD_START];
   assign sw_stop  = wr_fire && wr_lane && wr_idx == ct3_pkg::IDX_COMMAND &&
                     w_data_reg[ct3_pkg::CMD_STOP];

   // Timer events
   logic rx_halt;
   logic trim_start;
   logic trim_stop;
   logic start_evt;
   logic uf;
   assign rx_halt    = running && ctrl_reg[ct3_pkg::CTRL_HALT] &&
                       !trim_mode && rx_first_nibble;     // see [RULE1] [RULE2]
   assign trim_start = trim_mode && lfo_edge && !running; // see [RULE5] [RULE6]
   assign trim_stop  = trim_mode && lfo_edge && running;  // see [RULE5] [RULE6]
   assign start_evt  = sw_start || lpcd_start || trim_start ||
                       (src == ct3_pkg::SRC_TX_END && tx_end); // see [RULE3] [RULE4]
   // Measurement mode without underflow parks at zero instead
   assign uf = running && tick && count_reg == '0 &&
               src != ct3_pkg::SRC_TRIM;                  // see [RULE16]

   // Countdown core; stops beat starts in the same cycle
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= ct3_pkg::CT3_IDLE;
         count_reg <= '0;
      end
      else if (rx_halt || sw_stop || trim_stop)
         state_reg <= ct3_pkg::CT3_IDLE;                  // see [RULE1]
      else if (start_evt)
      begin
         state_reg <= ct3_pkg::CT3_RUN;
         count_reg <= reload_reg;                         // see [RULE12]
      end
      else if (running && tick)
      begin
         if (count_reg != '0)
            count_reg <= count_reg - 1'b1;                // see [RULE16]
         else if (uf && ctrl_reg[ct3_pkg::CTRL_AUTO])
            count_reg <= reload_reg;                      // see [RULE7]
         else if (uf)
            state_reg <= ct3_pkg::CT3_IDLE;               // see [RULE8]
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         uf_reg <= 1'b0;
      else
         uf_reg <= uf;
   end

   // Card detection field stays on while its countdown runs
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         field_reg <= 1'b0;
      else if (lpcd_start)
         field_reg <= 1'b1;                               // see [RULE15]
      else if (!running)
         field_reg <= 1'b0;                               // see [RULE15]
   end

   // Software registers; reload writes never touch the live count
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_reg   <= ct3_pkg::CTRL_RESET;
         reload_reg <= ct3_pkg::RELOAD_RESET;
         mask_reg   <= '0;
      end
      else if (wr_fire && wr_lane)
      begin
         case (wr_idx)
            ct3_pkg::IDX_CTRL:
               ctrl_reg <= w_data_reg[7:0] & ct3_pkg::CTRL_WMASK; // see [RULE17]
            ct3_pkg::IDX_RLD_HI:
               reload_reg[CNT_W-1:8] <= w_data_reg[CNT_W-9:0];    // see [RULE13]
            ct3_pkg::IDX_RLD_LO:
               reload_reg[7:0] <= w_data_reg[7:0];                // see [RULE13]
            ct3_pkg::IDX_MASK:
               mask_reg <= w_data_reg[ct3_pkg::ST_W-1:0];
            default:
               mask_reg <= mask_reg;
         endcase
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   logic [ct3_pkg::ST_W-1:0] st_set;
   logic [ct3_pkg::ST_W-1:0] st_clr;
   always_comb
   begin
      st_set = '0;
      st_set[ct3_pkg::ST_UNDERFLOW] = uf;                 // see [RULE9]
      st_set[ct3_pkg::ST_RX_HALT]   = rx_halt;
      st_set[ct3_pkg::ST_TRIM_DONE] = trim_stop;
      st_clr = '0;
      if (wr_fire && wr_lane && wr_idx == ct3_pkg::IDX_STATUS)
         st_clr = w_data_reg[ct3_pkg::ST_W-1:0];
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         status_reg <= '0;
      else
         status_reg <= (status_reg & ~st_clr) | st_set;
   end

   // Write channels taken in either order, response after both
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= ct3_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_map ? ct3_pkg::RESP_OKAY : ct3_pkg::RESP_SLVERR;
         end
         else if (bvalid_reg && s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   assign s_axi_awready = !aw_full_reg && !bvalid_reg;
   assign s_axi_wready  = !w_full_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   // Read channel; live count bytes may tear during reception
   logic [7:0]                 rd_idx;
   logic [ct3_pkg::DATA_W-1:0] rd_val;
   logic                       rd_ok;
   assign rd_idx = 8'(s_axi_araddr[ct3_pkg::ADDR_W-1:2]);
   always_comb
   begin
      rd_val = '0;
      rd_ok  = (s_axi_araddr[1:0] == 2'h0);
      case (rd_idx)
         ct3_pkg::IDX_CTRL:    rd_val[7:0] = ctrl_reg;
         ct3_pkg::IDX_RLD_HI:  rd_val[7:0] = reload_reg[CNT_W-1:8];
         ct3_pkg::IDX_RLD_LO:  rd_val[7:0] = reload_reg[7:0];
         ct3_pkg::IDX_CNT_HI:  rd_val[7:0] = count_reg[CNT_W-1:8]; // see [RULE14]
         ct3_pkg::IDX_CNT_LO:  rd_val[7:0] = count_reg[7:0];       // see [RULE14]
         ct3_pkg::IDX_STATUS:  rd_val[ct3_pkg::ST_W-1:0] = status_reg;
         ct3_pkg::IDX_MASK:    rd_val[ct3_pkg::ST_W-1:0] = mask_reg;
         ct3_pkg::IDX_COMMAND: rd_val[0] = running;
         default:              rd_ok = 1'b0;
      endcase
      if (!rd_ok)
         rd_val = '0;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= ct3_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_val;
         rresp_reg  <= rd_ok ? ct3_pkg::RESP_OKAY : ct3_pkg::RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   assign underflow_pulse = uf_reg;
   assign timer_running   = running;
   assign lpcd_field_on   = field_reg;
   assign irq             = |(status_reg & mask_reg);

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence uf_seq;
      uf && !rx_halt && !sw_stop && !trim_stop;
   endsequence

   sequence quiet_seq;
      !start_evt && !rx_halt && !sw_stop && !trim_stop;
   endsequence

   // A restart right after the halt legitimately reloads the count
   halt_receive_a: assert property ( // see [RULE1]
      rx_halt |=> !running ##1 ($stable(count_reg) || $past(start_evt)))
      else $error("Timer not halted after received nibble");
   trim_ignore_halt_a: assert property ( // see [RULE2]
      running && trim_mode && rx_first_nibble && !lfo_edge && !sw_stop &&
      !uf |=> running)
      else $error("Halt on receive acted in trimming mode");
   no_auto_start_a: assert property ( // see [RULE3]
      !running && src == ct3_pkg::SRC_NONE && !sw_start && !lpcd_start
      |=> !running)
      else $error("Timer started with no start source");
   tx_start_a: assert property ( // see [RULE4] [RULE12]
      src == ct3_pkg::SRC_TX_END && tx_end && !rx_halt && !sw_stop
      |=> running && count_reg == $past(reload_reg))
      else $error("Transmission end did not load and start");
   trim_park_a: assert property ( // see [RULE5]
      running && src == ct3_pkg::SRC_TRIM && tick && count_reg == '0 &&
      !start_evt |-> !uf ##1 count_reg == '0 && !underflow_pulse)
      else $error("Underflow seen in measurement mode");
   trim_cycle_a: assert property ( // see [RULE6]
      trim_start && !lpcd_start && !sw_stop |=> running ##0 trim_mode)
      else $error("Oscillator edge did not start trimming");
   auto_reload_a: assert property ( // see [RULE7]
      uf_seq ##0 ctrl_reg[ct3_pkg::CTRL_AUTO]
      |=> running && count_reg == $past(reload_reg))
      else $error("Counter not reloaded at zero");
   stop_zero_a: assert property ( // see [RULE8]
      uf_seq ##0 !ctrl_reg[ct3_pkg::CTRL_AUTO] && !start_evt
      |=> !running && count_reg == '0)
      else $error("Counter kept running after underflow");
   irq_flag_a: assert property ( // see [RULE9]
      uf |=> status_reg[ct3_pkg::ST_UNDERFLOW] && underflow_pulse)
      else $error("Underflow flag not set");
   decrement_a: assert property ( // see [RULE16]
      (running && tick && count_reg != '0) ##0 quiet_seq
      |=> count_reg == $past(count_reg) - 1'b1)
      else $error("Counter did not step by one");
   reload_hold_a: assert property ( // see [RULE13]
      (running && !tick) ##0 quiet_seq |=> $stable(count_reg))
      else $error("Live count disturbed without a tick");
   reserved_zero_a: assert property ( // see [RULE17]
      ctrl_reg[6] == 1'b0 && ctrl_reg[2] == 1'b0)
      else $error("Reserved control bit set");
   field_on_a: assert property ( // see [RULE15]
      lpcd_start |=> lpcd_field_on)
      else $error("Card detection field not raised");

endmodule : ct3_timer

// File: ct3_pkg.sv
// Constants and types for the third countdown timer block
// Function
// [RULE1] Halt-on-receive bit stops timer after nibble
// [RULE2] Halt-on-receive ignored in trimming modes
// [RULE3] Start source 00b never starts automatically
// [RULE4] Start source 01b starts at transmission end
// [RULE5] Source 10b trims oscillator, no underflow
// [RULE6] Source 11b trims oscillator, underflow allowed
// [RULE7] Reload-at-zero set reloads and keeps counting
// [RULE8] Reload-at-zero clear stops after underflow
// [RULE9] Every underflow sets the interrupt flag
// [RULE10] Clock select 00b/01b picks system/carrier tick
// [RULE11] Clock select 10b/11b cascades sibling underflows
// [RULE12] Start event loads counter from reload value
// [RULE13] Reload writes wait for next start event; here a reload at zero also takes the new value
// [RULE14] Software avoids reading count during reception
// [RULE15] Card detection uses timer for field-on time
// [RULE16] Counter decrements one per tick, underflows from zero
// [RULE17] Reserved control bits read zero, ignore writes
package ct3_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL     = 8'h1e;
   localparam logic [7:0] IDX_RLD_HI   = 8'h1f;
   localparam logic [7:0] IDX_RLD_LO   = 8'h20;
   localparam logic [7:0] IDX_CNT_HI   = 8'h21;
   localparam logic [7:0] IDX_CNT_LO   = 8'h22;
   localparam logic [7:0] IDX_STATUS   = 8'h30;
   localparam logic [7:0] IDX_MASK     = 8'h31;
   localparam logic [7:0] IDX_COMMAND  = 8'h32;
   // Control fields
   localparam int CTRL_HALT    = 7;
   localparam int CTRL_SRC_HI  = 5;
   localparam int CTRL_SRC_LO  = 4;
   localparam int CTRL_AUTO    = 3;
   localparam int CTRL_CLK_HI  = 1;
   localparam int CTRL_CLK_LO  = 0;
   localparam logic [7:0] CTRL_WMASK = 8'hbb;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   // Start sources and clock codes
   localparam logic [1:0] SRC_NONE     = 2'h0;
   localparam logic [1:0] SRC_TX_END   = 2'h1;
   localparam logic [1:0] SRC_TRIM     = 2'h2;
   localparam logic [1:0] SRC_TRIM_UF  = 2'h3;
   localparam logic [1:0] CLK_SYS      = 2'h0;
   localparam logic [1:0] CLK_CARRIER  = 2'h1;
   localparam logic [1:0] CLK_T0_UF    = 2'h2;
   localparam logic [1:0] CLK_T1_UF    = 2'h3;
   // Status / mask / command bits
   localparam int ST_UNDERFLOW = 0;
   localparam int ST_RX_HALT   = 1;
   localparam int ST_TRIM_DONE = 2;
   localparam int ST_W         = 3;
   localparam int CMD_START    = 0;
   localparam int CMD_STOP     = 1;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic {CT3_IDLE, CT3_RUN} ct3_state_e;
endpackage : ct3_pkg

// File: testbench.sv
// Self-checking testbench for the third countdown timer
`timescale 1ns/1ps
module testbench;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        arv = 1'b0;
   logic [7:0]  ev = 8'h00;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        uf, run, fld, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] r, q;
   logic [33:0] rq[$];
   logic [33:0] bq[$];
   int          miscompares = 0;
   int          checks_done = 0;
   int          ufn = 0;
   int          tn = 0;

   ct3_timer #(.CNT_W(16)) i_dut
   (
      .mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .sys_tick(ev[0]),
      .carrier_tick(ev[1]), .timer_zero_underflow(ev[2]),
      .timer_one_underflow(ev[3]), .tx_end(ev[4]),
      .rx_first_nibble(ev[5]), .lpcd_start(ev[6]),
      .low_frequency_oscillator(ev[7]), .underflow_pulse(uf),
      .timer_running(run), .lpcd_field_on(fld), .irq(irq)
   );

   initial
   begin
      forever #12.5 mclk = ~mclk;
   end

   task automatic cmp(input logic [33:0] g, input logic [33:0] e);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : cmp

   // Responses last one cycle with ready held high, so negedge sees each once
   always @(negedge mclk)
   begin
      if (rvalid)
         cmp({rresp, rdata}, rq.pop_front());
      if (bvalid)
         cmp({bresp, 32'h0}, bq.pop_front());
      if (uf)
         ufn <= ufn + 1;
   end

   task automatic wr(input logic [7:0] i, input logic [31:0] d,
                     input logic [1:0] e = 2'h0);
      logic pa, pw, a, w;
      bq.push_back({e, 32'h0});
      pa = 1'b1;
      pw = 1'b1;
      @(posedge mclk);
      awaddr <= i << 2;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      while (pa || pw)
      begin
         @(negedge mclk);
         a = pa && awready;
         w = pw && wready;
         @(posedge mclk);
         if (a)
         begin
            awv <= 1'b0;
            pa = 1'b0;
         end
         if (w)
         begin
            wv <= 1'b0;
            pw = 1'b0;
         end
      end
      @(negedge mclk);
      while (!bvalid) @(negedge mclk);
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic [7:0] i, input logic [31:0] d,
                     input logic [1:0] e = 2'h0);
      rq.push_back({e, d});
      @(posedge mclk);
      araddr <= i << 2;
      arv <= 1'b1;
      @(negedge mclk);
      while (!arready) @(negedge mclk);
      @(posedge mclk);
      arv <= 1'b0;
      @(negedge mclk);
      while (!rvalid) @(negedge mclk);
      @(posedge mclk);
   endtask : rd

   task automatic ev_p(input int k);
      @(posedge mclk);
      ev[k] <= 1'b1;
      @(posedge mclk);
      ev[k] <= 1'b0;
   endtask : ev_p

   // Oscillator held long enough to clear the three-stage synchroniser
   task automatic osc_edge;
      @(posedge mclk);
      ev[7] <= 1'b1;
      repeat (6) @(posedge mclk);
      ev[7] <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask : osc_edge

   task automatic look(input int k, input logic [33:0] e);
      @(negedge mclk);
      case (k)
         0: cmp(34'(irq), e);
         1: cmp(34'(fld), e);
         2: cmp(34'(ufn), e);
         default: cmp(34'(run), e);
      endcase
   endtask : look

   task automatic done_t;
      tn++;
      $display("test %0d ended", tn);
   endtask : done_t

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // Whole run needs a few hundred cycles; far beyond that means a hang
   initial
   begin
      #500000;
      miscompares++;
      give_verdict;
   end

   initial
   begin
      void'($urandom(96397));
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      rd(ct3_pkg::IDX_CTRL, 32'h0);
      rd(ct3_pkg::IDX_RLD_HI, 32'h0);
      rd(ct3_pkg::IDX_CNT_LO, 32'h0);
      rd(ct3_pkg::IDX_COMMAND, 32'h0);
      rd(8'h10, 32'h0, ct3_pkg::RESP_SLVERR);
      wr(8'h10, 32'h1, ct3_pkg::RESP_SLVERR);
      wr(ct3_pkg::IDX_CNT_LO, 32'h55);
      rd(ct3_pkg::IDX_CNT_LO, 32'h0);
      wr(ct3_pkg::IDX_CTRL, 32'hff);
      rd(ct3_pkg::IDX_CTRL, 32'hbb);
      done_t;
      wr(ct3_pkg::IDX_CTRL, 32'h0);
      wr(ct3_pkg::IDX_RLD_LO, 32'h2);
      wr(ct3_pkg::IDX_MASK, 32'h1);
      ev_p(4);
      rd(ct3_pkg::IDX_COMMAND, 32'h0);
      wr(ct3_pkg::IDX_CTRL, 32'h10);
      ev_p(4);
      rd(ct3_pkg::IDX_CNT_LO, 32'h2);
      rd(ct3_pkg::IDX_COMMAND, 32'h1);
      ev_p(0);
      ev_p(0);
      rd(ct3_pkg::IDX_CNT_LO, 32'h0);
      rd(ct3_pkg::IDX_STATUS, 32'h0);
      ev_p(0);
      rd(ct3_pkg::IDX_STATUS, 32'h1);
      rd(ct3_pkg::IDX_COMMAND, 32'h0);
      look(3, 34'h0);
      look(0, 34'h1);
      look(2, 34'h1);
      wr(ct3_pkg::IDX_MASK, 32'h0);
      look(0, 34'h0);
      wr(ct3_pkg::IDX_MASK, 32'h1);
      wr(ct3_pkg::IDX_STATUS, 32'h1);
      look(0, 34'h0);
      rd(ct3_pkg::IDX_STATUS, 32'h0);
      done_t;
      wr(ct3_pkg::IDX_CTRL, 32'h08);
      wr(ct3_pkg::IDX_RLD_LO, 32'h3);
      wr(ct3_pkg::IDX_COMMAND, 32'h1);
      wr(ct3_pkg::IDX_RLD_LO, 32'h1);
      rd(ct3_pkg::IDX_CNT_LO, 32'h3);
      repeat (4) ev_p(0);
      rd(ct3_pkg::IDX_CNT_LO, 32'h1);
      rd(ct3_pkg::IDX_COMMAND, 32'h1);
      look(2, 34'h2);
      wr(ct3_pkg::IDX_COMMAND, 32'h2);
      wr(ct3_pkg::IDX_STATUS, 32'h7);
      done_t;
      // Only the selected source may tick; the other three are ignored
      for (int c = 0; c < 4; c++)
      begin
         r = 16'($urandom) | 16'h0001;
         q = r - 16'h0001;
         wr(ct3_pkg::IDX_CTRL, 32'(c));
         wr(ct3_pkg::IDX_RLD_HI, {24'h0, r[15:8]});
         wr(ct3_pkg::IDX_RLD_LO, {24'h0, r[7:0]});
         wr(ct3_pkg::IDX_COMMAND, 32'h1);
         for (int k = 0; k < 4; k++)
            ev_p(k);
         rd(ct3_pkg::IDX_CNT_HI, {24'h0, q[15:8]});
         rd(ct3_pkg::IDX_CNT_LO, {24'h0, q[7:0]});
         wr(ct3_pkg::IDX_COMMAND, 32'h2);
      end
      done_t;
      wr(ct3_pkg::IDX_CTRL, 32'h90);
      wr(ct3_pkg::IDX_RLD_HI, 32'h0);
      wr(ct3_pkg::IDX_RLD_LO, 32'h5);
      ev_p(4);
      ev_p(0);
      ev_p(5);
      rd(ct3_pkg::IDX_COMMAND, 32'h0);
      // Count read only once the received nibble pulse is over
      rd(ct3_pkg::IDX_CNT_LO, 32'h4);
      wr(ct3_pkg::IDX_CTRL, 32'h10);
      ev_p(4);
      ev_p(5);
      rd(ct3_pkg::IDX_COMMAND, 32'h1);
      wr(ct3_pkg::IDX_COMMAND, 32'h2);
      wr(ct3_pkg::IDX_STATUS, 32'h7);
      done_t;
      wr(ct3_pkg::IDX_CTRL, 32'ha0);
      wr(ct3_pkg::IDX_RLD_LO, 32'h2);
      osc_edge;
      rd(ct3_pkg::IDX_COMMAND, 32'h1);
      ev_p(5);
      rd(ct3_pkg::IDX_COMMAND, 32'h1);
      repeat (4) ev_p(0);
      rd(ct3_pkg::IDX_CNT_LO, 32'h0);
      rd(ct3_pkg::IDX_STATUS, 32'h0);
      osc_edge;
      rd(ct3_pkg::IDX_COMMAND, 32'h0);
      wr(ct3_pkg::IDX_CTRL, 32'h30);
      wr(ct3_pkg::IDX_RLD_LO, 32'h1);
      osc_edge;
      repeat (2) ev_p(0);
      // Trim-done bit from the stop edge above is still pending
      rd(ct3_pkg::IDX_STATUS, 32'h5);
      look(2, 34'h3);
      wr(ct3_pkg::IDX_STATUS, 32'h7);
      done_t;
      wr(ct3_pkg::IDX_CTRL, 32'h0);
      ev_p(6);
      @(posedge mclk);
      look(1, 34'h1);
      rd(ct3_pkg::IDX_COMMAND, 32'h1);
      look(3, 34'h1);
      wr(ct3_pkg::IDX_COMMAND, 32'h2);
      repeat (2) @(posedge mclk);
      look(1, 34'h0);
      look(3, 34'h0);
      done_t;
      give_verdict;
   end
endmodule : testbench
